// file: rtl/bl_fade_regs.svh
// constants for the backlight dim timer and fade-rate block
// assumes a 200 MHz clock and register access over a plain byte port
// How it works
// - after dim delay expires, target drops from maximum to dim current
// - dim delay starts counting only once current reaches maximum
// - dim delay code bits 6:0; zero disables; n gives n seconds
// - nonzero fade-out code ramps current down to dim or off level
// - nonzero fade-in code ramps current up to maximum on switch-on
// - fade-out time applies to a full-scale ramp from top to zero
// - fade-in time applies to a full-scale ramp from zero to top
// - slope is fixed by code, so shorter changes finish sooner
// - fade-out code 1-10 gives 0.3 s steps, 11 up 0.5 s from 3.5 s
// - fade-in code 0 gives 0.1 s, 1-3 give 0.3-0.9 s, 15 gives 5.5 s
// - fade-out code zero still ramps, in about 100 ms
// - fade-in code zero still ramps, in about 100 ms
// - with dim enabled, off delay starts after dim expires; 1-127 s
`ifndef BL_FADE_REGS_SVH
`define BL_FADE_REGS_SVH

// ==========================================
// register map
`define DIM_DELAY_ADDR 8'h07
`define FADE_RATES_ADDR 8'h08
`define DIM_DELAY_RESET 8'h00
`define FADE_RATES_RESET 8'h00
`define DIM_CODE_MSB 6
`define FADE_DOWN_MSB 7
`define FADE_DOWN_LSB 4
`define FADE_UP_MSB 3
`define FADE_UP_LSB 0

// ==========================================
// timing
`define CLK_HZ 200000000
`define FAST_FADE_MS 100
`define RATE_STEP_MS 100
// one ramp step per DAC code; full scale is 127 codes
`define FULL_SCALE_CODES 127

`endif

// file: rtl/bl_fade_pkg.sv
// types for the backlight dim timer and fade-rate block
// assumes bl_fade_regs.svh supplies the numbers
package bl_fade_pkg;
    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_RISE = 4'b0010,
        ST_FULL = 4'b0100,
        ST_DIM = 4'b1000
    } bl_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage

// file: rtl/bl_step_timer.sv
// ramp-step pacing: one pulse per DAC code step for a rate code
// assumes a 200 MHz clock; the rate code may change at any time
`timescale 1ns/1ps
`include "bl_fade_regs.svh"
module bl_step_timer #(
    parameter int CLK_HZ = `CLK_HZ
) (
    input wire logic i_clk,          // system clock
    input wire logic i_rst_b,        // async reset, low
    input wire logic i_run,          // ramp in progress
    input wire logic [3:0] i_code,   // rate code
    output logic o_step              // one-cycle step pulse
);
    localparam int MS_CYC = CLK_HZ / 1000;

    // ==========================================
    // full-scale time in units of 100 ms
    function automatic int tenths(input logic [3:0] code);
        if (code == 4'h0) begin
            return `FAST_FADE_MS / `RATE_STEP_MS;
        end else if (code <= 4'ha) begin
            return 3 * int'(code);
        end else begin
            return 35 + 5 * (int'(code) - 11);
        end
    endfunction

    // cycles per code step: full-scale time over 127 codes, fixed slope
    logic [31:0] period;
    logic [31:0] cnt_r, cnt_nxt;
    logic step_nxt;

    always_comb begin
        period = 32'((longint'(tenths(i_code)) * `RATE_STEP_MS * MS_CYC)
            / `FULL_SCALE_CODES);
        cnt_nxt = cnt_r;
        step_nxt = 1'b0;
        if (!i_run) begin
            cnt_nxt = '0;
        end else if (cnt_r + 32'h1 >= period) begin
            cnt_nxt = '0;
            step_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= '0;
            o_step <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            o_step <= step_nxt;
        end
    end
endmodule

// file: rtl/bl_dim_fade.sv
// backlight sequencer: dim and off timers plus fade ramps
// assumes a byte-wide register port and levels given as 7-bit DAC codes
`timescale 1ns/1ps
`include "bl_fade_regs.svh"
module bl_dim_fade
    import bl_fade_pkg::*;
#(
    parameter int CLK_HZ = `CLK_HZ,
    parameter int SEC_CYCLES = `CLK_HZ
) (
    input wire logic i_clk,              // system clock
    input wire logic i_rst_b,            // async reset, low
    input wire reg_req_t i_req,          // register request
    output logic [7:0] o_rdata,          // read data, one cycle after rd
    output logic o_rvalid,               // read data valid pulse
    input wire logic i_bl_on,            // backlight switch-on request
    input wire logic [6:0] i_max_code,   // maximum current code
    input wire logic [6:0] i_dim_code,   // dim current code
    input wire logic [6:0] i_off_delay,  // off delay code, seconds
    output logic [6:0] o_level,          // present current code
    output logic o_dimmed,               // in dim phase
    output logic o_lit                   // backlight not off
);
    // ==========================================
    // registers
    logic [6:0] dim_delay_code_r, dim_delay_code_nxt;
    logic [7:0] fade_rates_r, fade_rates_nxt;
    logic [7:0] rdata_nxt;
    logic rvalid_nxt;
    logic [3:0] fade_down_rate_code;
    logic [3:0] fade_up_rate_code;

    assign fade_down_rate_code = fade_rates_r[`FADE_DOWN_MSB:`FADE_DOWN_LSB];
    assign fade_up_rate_code = fade_rates_r[`FADE_UP_MSB:`FADE_UP_LSB];

    always_comb begin
        dim_delay_code_nxt = dim_delay_code_r;
        fade_rates_nxt = fade_rates_r;
        rdata_nxt = 8'h00;
        rvalid_nxt = i_req.rd;
        if (i_req.wr) begin
            case (i_req.addr)
                `DIM_DELAY_ADDR: begin
                    dim_delay_code_nxt = i_req.wdata[`DIM_CODE_MSB:0];
                end
                `FADE_RATES_ADDR: begin
                    fade_rates_nxt = i_req.wdata;
                end
                default: begin
                end
            endcase
        end
        if (i_req.rd) begin
            case (i_req.addr)
                `DIM_DELAY_ADDR: rdata_nxt = {1'b0, dim_delay_code_r};
                `FADE_RATES_ADDR: rdata_nxt = fade_rates_r;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dim_delay_code_r <= 7'(`DIM_DELAY_RESET);
            fade_rates_r <= `FADE_RATES_RESET;
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else begin
            dim_delay_code_r <= dim_delay_code_nxt;
            fade_rates_r <= fade_rates_nxt;
            o_rdata <= rdata_nxt;
            o_rvalid <= rvalid_nxt;
        end
    end

    // ==========================================
    // one-second tick, restarted on entry to the full and dim phases
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic sec_tick;
    logic tick_clr;

    assign sec_tick = (tick_cnt_r == 32'(SEC_CYCLES - 1));

    always_comb begin
        if (tick_clr || sec_tick) begin
            tick_cnt_nxt = '0;
        end else begin
            tick_cnt_nxt = tick_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
        end
    end

    // ==========================================
    // sequencer and ramp
    bl_state_t state_r, state_nxt;
    logic [6:0] secs_r, secs_nxt;
    logic [6:0] level_r, level_nxt;
    logic [6:0] target;
    logic going_up, going_down, step;
    logic hold_off_r, hold_off_nxt;
    logic dimmed_nxt, lit_nxt;

    always_comb begin
        case (state_r)
            ST_RISE, ST_FULL: target = i_max_code;
            ST_DIM: target = i_dim_code;
            ST_OFF: target = 7'h00;
            default: target = 7'h00;
        endcase
    end

    assign going_up = (level_r < target);
    assign going_down = (level_r > target);

    // slope comes from the code of the direction in flight
    bl_step_timer #(
        .CLK_HZ(CLK_HZ)
    ) u_step (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_run(going_up || going_down),
        .i_code(going_up ? fade_up_rate_code : fade_down_rate_code),
        .o_step(step)
    );

    // one elapsed-seconds compare shared by the dim and off timers
    function automatic logic timer_done(input logic tick, input logic [6:0] secs,
                                        input logic [6:0] code);
        return tick && (code != 7'h00) && (7'(secs + 7'h01) == code);
    endfunction

    always_comb begin
        state_nxt = state_r;
        secs_nxt = secs_r;
        tick_clr = 1'b0;
        level_nxt = level_r;
        // one code per step from wherever the level stands
        if (step && going_up) begin
            level_nxt = level_r + 7'h01;
        end else if (step && going_down) begin
            level_nxt = level_r - 7'h01;
        end
        if (sec_tick) begin
            secs_nxt = secs_r + 7'h01;
        end
        case (state_r)
            ST_OFF: begin
                // after a timeout the switch must drop before a relight
                if (i_bl_on && !hold_off_r) begin
                    state_nxt = ST_RISE;
                end
            end
            ST_RISE: begin
                if (!i_bl_on) begin
                    state_nxt = ST_OFF;
                end else if (level_r == i_max_code) begin
                    state_nxt = ST_FULL;
                    secs_nxt = 7'h00;
                    tick_clr = 1'b1;
                end
            end
            ST_FULL: begin
                if (!i_bl_on) begin
                    state_nxt = ST_OFF;
                end else if (dim_delay_code_r != 7'h00) begin
                    if (timer_done(sec_tick, secs_r, dim_delay_code_r)) begin
                        state_nxt = ST_DIM;
                        secs_nxt = 7'h00;
                        tick_clr = 1'b1;
                    end
                end else if (timer_done(sec_tick, secs_r, i_off_delay)) begin
                    state_nxt = ST_OFF;
                end
            end
            ST_DIM: begin
                // off delay runs from the end of the dim delay
                if (!i_bl_on) begin
                    state_nxt = ST_OFF;
                end else if (timer_done(sec_tick, secs_r, i_off_delay)) begin
                    state_nxt = ST_OFF;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
    end

    // ==========================================
    // hold-off and output values
    // a timed-out backlight stays off until i_bl_on drops and rises again;
    // otherwise a held switch would relight at once and defeat the off timer
    always_comb begin
        hold_off_nxt = hold_off_r;
        if (state_r != ST_OFF && state_nxt == ST_OFF && i_bl_on) begin
            hold_off_nxt = 1'b1;
        end else if (!i_bl_on) begin
            hold_off_nxt = 1'b0;
        end
        dimmed_nxt = (state_nxt == ST_DIM);
        lit_nxt = (state_nxt != ST_OFF) || (level_nxt != 7'h00);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_OFF;
            secs_r <= 7'h00;
            level_r <= 7'h00;
            hold_off_r <= 1'b0;
            o_level <= 7'h00;
            o_dimmed <= 1'b0;
            o_lit <= 1'b0;
        end else begin
            state_r <= state_nxt;
            secs_r <= secs_nxt;
            level_r <= level_nxt;
            hold_off_r <= hold_off_nxt;
            o_level <= level_nxt;
            o_dimmed <= dimmed_nxt;
            o_lit <= lit_nxt;
        end
    end
endmodule

// file: tb/bl_dim_fade_properties.sv
// port assertions for the backlight sequencer
// assumes a bind from the testbench top; one clock domain
`timescale 1ns/1ps
module bl_dim_fade_checker
    import bl_fade_pkg::*;
(
    input wire logic i_clk,            // clock
    input wire logic i_rst_b,          // reset, low
    input wire reg_req_t i_req,        // register request
    input wire logic [7:0] o_rdata,    // read data
    input wire logic o_rvalid,         // read valid
    input wire logic i_bl_on,          // switch-on
    input wire logic [6:0] i_max_code, // max code
    input wire logic [6:0] i_dim_code, // dim code
    input wire logic [6:0] o_level,    // level
    input wire logic o_dimmed,         // dim phase
    input wire logic o_lit             // lit
);
    // ==========================================
    // properties
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_read_answer: assert property (i_req.rd |=> o_rvalid)
        else $error("no read answer");
    a_read_pulse: assert property (!i_req.rd |=> !o_rvalid)
        else $error("stray read valid");
    a_unmapped_zero: assert property (i_req.rd && i_req.addr != 8'h07 && i_req.addr != 8'h08
        |=> o_rdata == 8'h00) else $error("unmapped read not zero");
    a_reserved_zero: assert property (i_req.rd && i_req.addr == 8'h07 |=> !o_rdata[7])
        else $error("reserved bit set");
    a_level_ramp: assert property (
        o_level == $past(o_level) || o_level == $past(o_level) + 7'h01
        || o_level == $past(o_level) - 7'h01) else $error("level stepped");
    a_lit_nonzero: assert property (o_level != 7'h00 |-> o_lit)
        else $error("dark with current");
    // the switch takes one edge to reach the ramp target and two to reach o_level
    a_dark_falls: assert property (!$past(i_bl_on) && !$past(i_bl_on, 2)
        |-> o_level <= $past(o_level)) else $error("rise while off");
    a_dim_falls: assert property (o_dimmed && $past(o_dimmed) && i_dim_code <= i_max_code
        |-> o_level <= $past(o_level)) else $error("rise while dimmed");
endmodule

// file: tb/bl_host_model.sv
// host model: single-byte register writes and reads
// assumes the read answer stands one cycle after the request edge
`timescale 1ns/1ps
module bl_host_model
    import bl_fade_pkg::*;
(
    input wire logic i_clk,         // clock
    input wire logic [7:0] i_rdata, // read data
    input wire logic i_rvalid,      // read valid
    output reg_req_t o_req          // request to device
);
    initial o_req = '0;
    // ==========================================
    // one access; request held across its taking edge only
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
        @(posedge i_clk);
        o_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge i_clk);
        o_req <= '0;
        #1;
        ok = w | (i_rvalid === 1'b1);
        q = i_rdata;
    endtask
endmodule

// file: tb/testbench.sv
// testbench: register table, ramp times per rate code, dim and off timers
// assumes shortened clock rate and second; 12 cycles a ms, so about 9.45 cycles a step per 0.1 s
`timescale 1ns/1ps
module testbench;
    import bl_fade_pkg::*;
    localparam int CLK_HZ = 12700;
    localparam int SEC_CYCLES = 50;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic i_clk, i_rst_b, i_bl_on, o_rvalid, o_dimmed, o_lit, ok;
    logic [6:0] i_max_code, i_dim_code, i_off_delay, o_level;
    logic [7:0] o_rdata, q;
    reg_req_t i_req;
    int err_total = 0;
    int checks = 0;
    int n, m;
    row_t rows [6] = '{'{1'b0, 8'h07, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'h00},
        '{1'b1, 8'h07, 8'hff, 8'h7f}, '{1'b1, 8'h08, 8'ha5, 8'ha5},
        '{1'b1, 8'h0a, 8'h3c, 8'h00}, '{1'b1, 8'h07, 8'h00, 8'h00}};
    bl_dim_fade #(.CLK_HZ(CLK_HZ), .SEC_CYCLES(SEC_CYCLES)) bl_dim_fade_i (.i_clk(i_clk),
        .i_rst_b(i_rst_b), .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
        .i_bl_on(i_bl_on), .i_max_code(i_max_code), .i_dim_code(i_dim_code),
        .i_off_delay(i_off_delay), .o_level(o_level), .o_dimmed(o_dimmed), .o_lit(o_lit));
    bl_host_model bl_host_model_i (.i_clk(i_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid),
        .o_req(i_req));
    // ==========================================
    // helpers
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        chk(32'(got), 32'((got >= lo && got <= hi) ? got : lo));
    endtask
    task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
        bl_host_model_i.xfer(w, a, d, q, ok);
    endtask
    // kind 0: level equals v, 1: dim phase entered, 2: backlight dark
    task automatic wait_for(input int kind, input logic [6:0] v, output int cnt);
        cnt = 0;
        while (!(kind == 0 ? o_level === v : kind == 1 ? o_dimmed === 1'b1 : o_lit === 1'b0)) begin
            @(posedge i_clk);
            #1;
            cnt++;
            if (cnt > 30000) begin
                err_total++;
                end_of_test();
            end
        end
    endtask
    // tenths of a second for a full-scale ramp
    function automatic int tenths(input int c);
        return c == 0 ? 1 : c <= 10 ? 3 * c : 35 + 5 * (c - 11);
    endfunction
    // ==========================================
    // stimulus
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        i_rst_b = 1'b0;
        i_bl_on = 1'b0;
        i_max_code = 7'h04;
        i_dim_code = 7'h02;
        i_off_delay = 7'h00;
        repeat (20) @(posedge i_clk);
        chk({o_level, o_dimmed, o_lit, o_rvalid}, 32'h0);
        i_rst_b <= 1'b1;
        foreach (rows[k]) begin
            if (rows[k].w) io(1'b1, rows[k].a, rows[k].d);
            io(1'b0, rows[k].a, 8'h00);
            chk(ok, 1'b1);
            chk(q, rows[k].e);
        end
        $display("register table done");
        // every rate code, up then down over four steps
        for (int c = 0; c < 16; c++) begin
            io(1'b1, 8'h08, {c[3:0], c[3:0]});
            @(posedge i_clk);
            i_bl_on <= 1'b1;
            wait_for(0, 7'h04, n);
            chk_rng(n, 30 * tenths(c), 50 * tenths(c) + 4);
            @(posedge i_clk);
            i_bl_on <= 1'b0;
            wait_for(0, 7'h00, n);
            chk_rng(n, 30 * tenths(c), 50 * tenths(c) + 4);
        end
        $display("ramp rates done");
        @(posedge i_clk);
        i_max_code <= 7'h08;
        i_off_delay <= 7'h03;
        io(1'b1, 8'h08, 8'h00);
        io(1'b1, 8'h07, 8'h02);
        @(posedge i_clk);
        i_bl_on <= 1'b1;
        wait_for(0, 7'h08, n);
        chk(o_dimmed, 1'b0);
        wait_for(1, 7'h00, n);
        chk_rng(n, 2 * SEC_CYCLES - 2, 2 * SEC_CYCLES + 12);
        wait_for(0, 7'h02, m);
        chk_rng(m, 50, 74);
        wait_for(2, 7'h00, n);
        chk_rng(n + m, 3 * SEC_CYCLES, 3 * SEC_CYCLES + 35);
        // switch still held: a timed-out backlight must stay dark
        repeat (20) @(posedge i_clk);
        #1;
        chk(o_lit, 1'b0);
        @(posedge i_clk);
        i_bl_on <= 1'b0;
        $display("dim and off timers done");
        // relight, then reset in mid-ramp: outputs and registers back to zero
        repeat (2) @(posedge i_clk);
        i_bl_on <= 1'b1;
        wait_for(0, 7'h03, n);
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        i_bl_on <= 1'b0;
        repeat (20) @(posedge i_clk);
        #1;
        chk({o_level, o_dimmed, o_lit, o_rvalid}, 32'h0);
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        io(1'b0, 8'h07, 8'h00);
        chk(q, 8'h00);
        io(1'b0, 8'h08, 8'h00);
        chk(q, 8'h00);
        $display("mid-run reset done");
        end_of_test();
    end
endmodule

bind bl_dim_fade bl_dim_fade_checker bl_dim_fade_checker_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_bl_on(i_bl_on),
    .i_max_code(i_max_code), .i_dim_code(i_dim_code), .o_level(o_level),
    .o_dimmed(o_dimmed), .o_lit(o_lit));
